// file: common/gerr_pkg.sv
// Purpose: Shared constants and types of the controller.
// Assumes: One 100 MHz clock, asynchronous active-low reset.
// Notes:   Field selects address the field access port.
`default_nettype none
package gerr_pkg;

   // Info layout
   localparam int          INFO_ERRV_BIT     = 11;
   localparam int          INFO_UNBLK_BIT    = 12;
   localparam int          INFO_VALID_BIT    = 31;
   localparam logic [31:0] INFO_RSV_MASK     = 32'h7FFF_F000;
   localparam logic [31:0] RST_WORD          = 32'h0000_0000;

   // Interruption types
   localparam logic [2:0]  TYPE_NMI          = 3'h2;
   localparam logic [2:0]  TYPE_HW_EXC       = 3'h3;
   localparam logic [2:0]  TYPE_SW_INT       = 3'h4;
   localparam logic [2:0]  TYPE_PRIV_SW_EXC  = 3'h5;
   localparam logic [2:0]  TYPE_SW_EXC       = 3'h6;

   // Vectors
   localparam logic [7:0]  VEC_DE            = 8'h00;
   localparam logic [7:0]  VEC_DF            = 8'h08;
   localparam logic [7:0]  VEC_BR            = 8'h09;
   localparam logic [7:0]  VEC_TS            = 8'h0A;
   localparam logic [7:0]  VEC_GP            = 8'h0D;
   localparam logic [7:0]  VEC_PF            = 8'h0E;
   localparam logic [7:0]  VEC_MF            = 8'h10;
   localparam logic [7:0]  VEC_XM            = 8'h13;
   localparam logic [7:0]  VEC_DB            = 8'h01;
   localparam logic [7:0]  VEC_NM            = 8'h07;

   // Blocking-by-NMI bit
   localparam int          IST_NMI_BLK_BIT   = 3;

   // Field selects
   localparam logic [3:0]  FLD_EXIT_INFO     = 4'h0;
   localparam logic [3:0]  FLD_EXIT_ERR      = 4'h1;
   localparam logic [3:0]  FLD_VECT_INFO     = 4'h2;
   localparam logic [3:0]  FLD_VECT_ERR      = 4'h3;
   localparam logic [3:0]  FLD_EXIT_ILEN     = 4'h4;
   localparam logic [3:0]  FLD_ENTRY_INFO    = 4'h5;
   localparam logic [3:0]  FLD_ENTRY_ERR     = 4'h6;
   localparam logic [3:0]  FLD_ENTRY_ILEN    = 4'h7;
   localparam logic [3:0]  FLD_INTR_STATE    = 4'h8;
   localparam logic [3:0]  FLD_RESUME        = 4'h9;
   localparam int          RESUME_FAIL_BIT   = 0;

   // Own register offsets
   localparam logic [7:0]  REG_CTRL          = 8'h00;
   localparam logic [7:0]  REG_STATUS        = 8'h04;
   localparam logic [7:0]  REG_EXIT_INFO     = 8'h08;
   localparam logic [7:0]  REG_VECT_INFO     = 8'h0C;
   localparam logic [7:0]  REG_ENTRY_INFO    = 8'h10;

   // Control bits
   localparam int          CTRL_START_BIT    = 0;
   localparam int          CTRL_RESUME_BIT   = 1;
   localparam int          CTRL_NMI_EXIT_BIT = 2;
   localparam int          CTRL_VNMI_BIT     = 3;

   localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
   localparam logic        HRESP_OKAY        = 1'b0;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] wdata;
   } gerr_fld_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } gerr_fld_rsp_t;

   typedef struct packed {
      logic [31:0] entry_info;
      logic [31:0] entry_err;
      logic        wr_err;
      logic        wr_ilen;
      logic        set_blk;
      logic        clr_blk;
      logic        dbl;
      logic        triple;
      logic        nested;
   } gerr_dec_t;

endpackage : gerr_pkg
`default_nettype wire

// file: hdl/gerr_classify.sv
// Purpose: Registered event decision from saved fields.
// Assumes: Inputs held a clock before use.
// Notes:   Result one clock after inputs.
`default_nettype none
`timescale 1ns/1ns
module gerr_classify (
   input  wire logic                hclk,        // Clock
   input  wire logic                hresetn,     // Async reset, low
   input  wire logic                op_resume,   // 1 resume, 0 reflect
   input  wire logic                nmi_exiting, // NMI exit control
   input  wire logic                virt_nmi,    // Virtual NMI control
   input  wire logic [31:0]         exit_info,   // Exit event info
   input  wire logic [31:0]         exit_err,    // Exit error code
   input  wire logic [31:0]         vect_info,   // Interrupted delivery
   input  wire logic [31:0]         vect_err,    // Its error code
   output var  gerr_pkg::gerr_dec_t dec          // Registered decision
);

   function automatic logic is_benign(input logic [7:0] v);
      return (v >= gerr_pkg::VEC_DB && v <= gerr_pkg::VEC_NM) ||
             (v == gerr_pkg::VEC_BR) ||
             (v >= gerr_pkg::VEC_MF && v <= gerr_pkg::VEC_XM);
   endfunction : is_benign

   function automatic logic is_contrib(input logic [7:0] v);
      return (v == gerr_pkg::VEC_DE) ||
             (v >= gerr_pkg::VEC_TS && v <= gerr_pkg::VEC_GP);
   endfunction : is_contrib

   wire logic [7:0] evec   = exit_info[7:0];
   wire logic [7:0] vvec   = vect_info[7:0];
   wire logic [2:0] vtype  = vect_info[10:8];
   wire logic       vvalid = vect_info[gerr_pkg::INFO_VALID_BIT];
   wire logic       vhw    = vtype == gerr_pkg::TYPE_HW_EXC;  // see RQ6
   wire logic       triple = vvalid && vhw &&
                             vvec == gerr_pkg::VEC_DF;        // see RQ11
   wire logic       keep   = !vhw || is_benign(vvec) ||       // see RQ7
                             is_benign(evec) ||               // see RQ8
                             (is_contrib(vvec) && evec == gerr_pkg::VEC_PF);
   wire logic       dbl    = vvalid && vhw && !triple && !keep &&
                             ((is_contrib(vvec) && is_contrib(evec)) ||
                              (vvec == gerr_pkg::VEC_PF &&
                               (is_contrib(evec) ||
                                evec == gerr_pkg::VEC_PF)));  // see RQ9
   wire logic [31:0] df_info = {1'b1, 19'h0_0000, 1'b1,
                                gerr_pkg::TYPE_HW_EXC,
                                gerr_pkg::VEC_DF};            // see RQ10
   wire logic       blk_case = !vvalid && evec != gerr_pkg::VEC_DF &&
                               exit_info[gerr_pkg::INFO_UNBLK_BIT];
   wire logic       sw_type = vtype == gerr_pkg::TYPE_SW_INT ||
                              vtype == gerr_pkg::TYPE_PRIV_SW_EXC ||
                              vtype == gerr_pkg::TYPE_SW_EXC;

   gerr_pkg::gerr_dec_t dec_nxt;

   always_comb begin
      dec_nxt = '0;
      dec_nxt.nested = vvalid;
      if (!op_resume) begin
         if (triple) begin
            dec_nxt.triple = 1'b1;                            // see RQ11
         end else if (dbl) begin
            dec_nxt.dbl        = 1'b1;
            dec_nxt.entry_info = df_info;                     // see RQ10
            dec_nxt.entry_err  = gerr_pkg::RST_WORD;
            dec_nxt.wr_err     = 1'b1;
         end else begin
            // Reserved bits and the unblock flag must not be copied
            dec_nxt.entry_info = exit_info &
                                 ~gerr_pkg::INFO_RSV_MASK;    // see RQ1 RQ3 RQ4
            dec_nxt.entry_err  = exit_err;
            dec_nxt.wr_err     = exit_info[gerr_pkg::INFO_ERRV_BIT]; // see RQ2
         end
      end else if (vvalid) begin
         dec_nxt.entry_info = vect_info &
                              ~gerr_pkg::INFO_RSV_MASK;       // see RQ14 RQ15
         dec_nxt.entry_err  = vect_err;
         dec_nxt.wr_err     = vect_info[gerr_pkg::INFO_ERRV_BIT]; // see RQ17
         dec_nxt.wr_ilen    = sw_type;                        // see RQ18
         dec_nxt.clr_blk    = virt_nmi &&
                              vtype == gerr_pkg::TYPE_NMI;    // see RQ16
      end else begin
         dec_nxt.set_blk = blk_case &&
                           (!nmi_exiting || virt_nmi);        // see RQ12 RQ13
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dec <= '0;                                           // see RQ20
      end else begin
         dec <= dec_nxt;                                      // see RQ19
      end
   end

endmodule : gerr_classify
`default_nettype wire

// file: hdl/gerr_top.sv
// Purpose: Reflects a guest exception or resumes the guest
//          through the control structure fields.
// Assumes: Field partner on hclk; single word AHB-Lite.
// Notes:   Contract
// Contract
// RQ1 - Reflect: copy exit info to entry, resume
// RQ2 - Copy exit error code when its valid
// RQ3 - Entry bits 30:12 nonzero fail entry
// RQ4 - Exit bit 12 must not be copied
// RQ5 - Vectoring valid means nested event handling
// RQ6 - Info layout: vector, type, errv, valid
// RQ7 - Reflect if not hardware or benign
// RQ8 - Reflect if exit benign or contrib-then-PF
// RQ9 - Double fault on contributory or PF pairs
// RQ10 - Double fault: vector 8, type 3, code 0
// RQ11 - Vectoring double fault means triple, no inject
// RQ12 - NMI exiting off: set NMI blocking
// RQ13 - Virtual NMI on: set NMI blocking
// RQ14 - Resume replays vectoring event into entry
// RQ15 - Replay clears entry bits 30:12
// RQ16 - Virtual NMI replay clears NMI blocking
// RQ17 - Replay copies vectoring error code if valid
// RQ18 - Instruction length only for software types
// RQ19 - Decision registered one clock after inputs
// RQ20 - Reset clears entry info and flags
`default_nettype none
`timescale 1ns/1ns
module gerr_top (
   input  wire logic                    hclk,      // Clock, 100 MHz
   input  wire logic                    hresetn,   // Async reset, low
   input  wire logic                    hsel,      // Slave select
   input  wire logic [31:0]             haddr,     // Address
   input  wire logic [1:0]              htrans,    // Transfer type
   input  wire logic                    hwrite,    // Write
   input  wire logic [2:0]              hsize,     // Size, word only
   input  wire logic [31:0]             hwdata,    // Write data
   input  wire logic                    hready,    // Bus ready
   output logic                         hreadyout, // Slave ready
   output logic                         hresp,     // Response
   output logic [31:0]                  hrdata,    // Read data
   output var  gerr_pkg::gerr_fld_req_t fld_req,   // Field request
   input  wire gerr_pkg::gerr_fld_rsp_t fld_rsp    // Field answer
);

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_RD_EXIT  = 4'b0001,
      ST_RD_EXERR = 4'b0011,
      ST_RD_VECT  = 4'b0010,
      ST_RD_VERR  = 4'b0110,
      ST_RD_ILEN  = 4'b0111,
      ST_RD_IST   = 4'b0101,
      ST_CALC     = 4'b0100,
      ST_HOLD     = 4'b1100,
      ST_WR_INFO  = 4'b1101,
      ST_WR_ERR   = 4'b1111,
      ST_WR_ILEN  = 4'b1110,
      ST_WR_IST   = 4'b1010,
      ST_RESUME   = 4'b1011,
      ST_DONE     = 4'b1001
   } gerr_state_t;

   gerr_state_t             state_r;
   gerr_state_t             state_nxt;
   gerr_pkg::gerr_fld_req_t req_nxt;
   gerr_pkg::gerr_dec_t     dec;

   // Bus slave state
   logic        wr_pend_r;
   logic [7:0]  wr_addr_r;
   logic [31:0] rd_data_r;
   logic [31:0] rd_data_nxt;

   // Own registers
   logic        op_resume_r;
   logic        nmi_exit_r;
   logic        vnmi_r;
   logic        done_r;
   logic        fail_r;
   logic [31:0] exit_info_r;
   logic [31:0] exit_err_r;
   logic [31:0] vect_info_r;
   logic [31:0] vect_err_r;
   logic [31:0] ilen_r;
   logic [31:0] ist_r;
   logic [31:0] entry_info_r;

   // Address phase and write decode
   wire logic        addr_ok  = hsel && hready && htrans == 
                                gerr_pkg::HTRANS_NONSEQ;
   wire logic        rd_take  = addr_ok && !hwrite;
   wire logic        wr_take  = addr_ok && hwrite;
   wire logic [7:0]  a_off    = haddr[7:0];
   wire logic        wr_ctrl  = wr_pend_r && wr_addr_r == gerr_pkg::REG_CTRL;
   wire logic        busy     = state_r != ST_IDLE;
   wire logic        start_go = wr_ctrl && !busy &&
                                hwdata[gerr_pkg::CTRL_START_BIT];
   wire logic        xfer     = fld_req.req && fld_rsp.ack;
   wire logic        res_fail = xfer && state_r == ST_RESUME &&
                                fld_rsp.rdata[gerr_pkg::RESUME_FAIL_BIT];
   wire logic [31:0] ctrl_word = {28'h000_0000, vnmi_r, nmi_exit_r,
                                  op_resume_r, 1'b0};
   wire logic [31:0] sts_word  = {26'h000_0000, dec.nested, fail_r,
                                  dec.triple, dec.dbl, done_r, busy};
   wire logic [31:0] ist_set   = ist_r |
                                 (32'h0000_0001 << gerr_pkg::IST_NMI_BLK_BIT);
   wire logic [31:0] ist_clr   = ist_r &
                                 ~(32'h0000_0001 << gerr_pkg::IST_NMI_BLK_BIT);

   // Skip writes not called for
   wire gerr_state_t after_ist  = dec.triple ? ST_DONE : ST_RESUME;
   wire gerr_state_t after_ilen = (dec.set_blk || dec.clr_blk) ?
                                  ST_WR_IST : after_ist;
   wire gerr_state_t after_err  = dec.wr_ilen ? ST_WR_ILEN : after_ilen;
   wire gerr_state_t after_info = dec.wr_err ? ST_WR_ERR : after_err;

   assign hreadyout = 1'b1;
   assign hresp     = gerr_pkg::HRESP_OKAY;
   assign hrdata    = rd_data_r;

   gerr_classify u_classify (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .op_resume   (op_resume_r),
      .nmi_exiting (nmi_exit_r),
      .virt_nmi    (vnmi_r),
      .exit_info   (exit_info_r),
      .exit_err    (exit_err_r),
      .vect_info   (vect_info_r),
      .vect_err    (vect_err_r),
      .dec         (dec)
   );

   // Read data set in address phase
   always_comb begin
      rd_data_nxt = rd_data_r;
      if (rd_take) begin
         if (a_off == gerr_pkg::REG_CTRL) begin
            rd_data_nxt = ctrl_word;
         end else if (a_off == gerr_pkg::REG_STATUS) begin
            rd_data_nxt = sts_word;
         end else if (a_off == gerr_pkg::REG_EXIT_INFO) begin
            rd_data_nxt = exit_info_r;
         end else if (a_off == gerr_pkg::REG_VECT_INFO) begin
            rd_data_nxt = vect_info_r;
         end else if (a_off == gerr_pkg::REG_ENTRY_INFO) begin
            rd_data_nxt = entry_info_r;
         end else begin
            rd_data_nxt = gerr_pkg::RST_WORD;
         end
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start_go) begin
               state_nxt = ST_RD_EXIT;
            end
         end
         ST_RD_EXIT: begin
            if (xfer) begin
               state_nxt = ST_RD_EXERR;
            end
         end
         ST_RD_EXERR: begin
            if (xfer) begin
               state_nxt = ST_RD_VECT;
            end
         end
         ST_RD_VECT: begin
            if (xfer) begin
               state_nxt = ST_RD_VERR;
            end
         end
         ST_RD_VERR: begin
            if (xfer) begin
               state_nxt = ST_RD_ILEN;
            end
         end
         ST_RD_ILEN: begin
            if (xfer) begin
               state_nxt = ST_RD_IST;
            end
         end
         ST_RD_IST: begin
            if (xfer) begin
               state_nxt = ST_CALC;
            end
         end
         ST_CALC: begin
            state_nxt = ST_HOLD;
         end
         ST_HOLD: begin
            state_nxt = ST_WR_INFO;
         end
         ST_WR_INFO: begin
            if (xfer) begin
               state_nxt = after_info;
            end
         end
         ST_WR_ERR: begin
            if (xfer) begin
               state_nxt = after_err;
            end
         end
         ST_WR_ILEN: begin
            if (xfer) begin
               state_nxt = after_ilen;
            end
         end
         ST_WR_IST: begin
            if (xfer) begin
               state_nxt = after_ist;
            end
         end
         ST_RESUME: begin
            if (xfer) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Request for the entered state
   always_comb begin
      req_nxt = '0;
      case (state_nxt)
         ST_RD_EXIT: begin
            req_nxt.req = 1'b1;
            req_nxt.sel = gerr_pkg::FLD_EXIT_INFO;
         end
         ST_RD_EXERR: begin
            req_nxt.req = 1'b1;
            req_nxt.sel = gerr_pkg::FLD_EXIT_ERR;
         end
         ST_RD_VECT: begin
            req_nxt.req = 1'b1;
            req_nxt.sel = gerr_pkg::FLD_VECT_INFO;           // see RQ5
         end
         ST_RD_VERR: begin
            req_nxt.req = 1'b1;
            req_nxt.sel = gerr_pkg::FLD_VECT_ERR;
         end
         ST_RD_ILEN: begin
            req_nxt.req = 1'b1;
            req_nxt.sel = gerr_pkg::FLD_EXIT_ILEN;
         end
         ST_RD_IST: begin
            req_nxt.req = 1'b1;
            req_nxt.sel = gerr_pkg::FLD_INTR_STATE;
         end
         ST_WR_INFO: begin
            req_nxt.req   = 1'b1;
            req_nxt.we    = 1'b1;
            req_nxt.sel   = gerr_pkg::FLD_ENTRY_INFO;
            req_nxt.wdata = dec.entry_info;                  // see RQ3 RQ11
         end
         ST_WR_ERR: begin
            req_nxt.req   = 1'b1;
            req_nxt.we    = 1'b1;
            req_nxt.sel   = gerr_pkg::FLD_ENTRY_ERR;
            req_nxt.wdata = dec.entry_err;                   // see RQ2 RQ17
         end
         ST_WR_ILEN: begin
            req_nxt.req   = 1'b1;
            req_nxt.we    = 1'b1;
            req_nxt.sel   = gerr_pkg::FLD_ENTRY_ILEN;
            req_nxt.wdata = ilen_r;                          // see RQ18
         end
         ST_WR_IST: begin
            req_nxt.req   = 1'b1;
            req_nxt.we    = 1'b1;
            req_nxt.sel   = gerr_pkg::FLD_INTR_STATE;
            req_nxt.wdata = dec.set_blk ? ist_set : ist_clr; // see RQ12 RQ16
         end
         ST_RESUME: begin
            req_nxt.req = 1'b1;
            req_nxt.we  = 1'b1;
            req_nxt.sel = gerr_pkg::FLD_RESUME;              // see RQ1 RQ14
         end
         default: begin
            req_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_IDLE;
         fld_req <= '0;
      end else begin
         state_r <= state_nxt;
         fld_req <= req_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rd_data_r <= gerr_pkg::RST_WORD;
      end else begin
         wr_pend_r <= wr_take;
         wr_addr_r <= wr_take ? a_off : wr_addr_r;
         rd_data_r <= rd_data_nxt;
      end
   end

   // Mode bits held while busy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_resume_r <= 1'b0;
         nmi_exit_r  <= 1'b0;
         vnmi_r      <= 1'b0;
      end else if (wr_ctrl && !busy) begin
         op_resume_r <= hwdata[gerr_pkg::CTRL_RESUME_BIT];
         nmi_exit_r  <= hwdata[gerr_pkg::CTRL_NMI_EXIT_BIT];
         vnmi_r      <= hwdata[gerr_pkg::CTRL_VNMI_BIT];
      end
   end

   // Set wins over start clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_r <= 1'b0;
         fail_r <= 1'b0;
      end else begin
         done_r <= (state_r == ST_DONE) || (done_r && !start_go);
         fail_r <= res_fail || (fail_r && !start_go);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exit_info_r <= gerr_pkg::RST_WORD;
         exit_err_r  <= gerr_pkg::RST_WORD;
         vect_info_r <= gerr_pkg::RST_WORD;
         vect_err_r  <= gerr_pkg::RST_WORD;
         ilen_r      <= gerr_pkg::RST_WORD;
         ist_r       <= gerr_pkg::RST_WORD;
      end else if (xfer && !fld_req.we) begin
         exit_info_r <= state_r == ST_RD_EXIT  ? fld_rsp.rdata : exit_info_r;
         exit_err_r  <= state_r == ST_RD_EXERR ? fld_rsp.rdata : exit_err_r;
         vect_info_r <= state_r == ST_RD_VECT  ? fld_rsp.rdata : vect_info_r;
         vect_err_r  <= state_r == ST_RD_VERR  ? fld_rsp.rdata : vect_err_r;
         ilen_r      <= state_r == ST_RD_ILEN  ? fld_rsp.rdata : ilen_r;
         ist_r       <= state_r == ST_RD_IST   ? fld_rsp.rdata : ist_r;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         entry_info_r <= gerr_pkg::RST_WORD;                  // see RQ20
      end else if (xfer && state_r == ST_WR_INFO) begin
         entry_info_r <= fld_req.wdata;
      end
   end

endmodule : gerr_top
`default_nettype wire

// file: tb/gerr_top_props.sv
// Purpose: Port assertions for gerr_top.
// Assumes: One clock, async low reset.
// Notes:   Bound below.
`timescale 1ns/1ns
`default_nettype none
module gerr_top_props (
   input wire logic                    hclk,      // Clock
   input wire logic                    hresetn,   // Reset, low
   input wire logic                    hreadyout, // Slave ready
   input wire logic                    hresp,     // Response
   input wire gerr_pkg::gerr_fld_req_t fld_req,   // Field request
   input wire gerr_pkg::gerr_fld_rsp_t fld_rsp    // Field answer
);
   logic [31:0] ex_r;
   logic [31:0] vc_r;
   logic        ent_r;
   logic        dbl_r;
   wire  logic  ack = fld_req.req & fld_rsp.ack;
   wire  logic  wr  = fld_req.req & fld_req.we;
   wire  logic  ent = wr & (fld_req.sel == 4'h5);
   wire  logic  res = wr & (fld_req.sel == 4'h9);
   wire  logic  rd0 = ack & !fld_req.we & (fld_req.sel == 4'h0);
   wire  logic  rd2 = ack & !fld_req.we & (fld_req.sel == 4'h2);
   // Captures this run's fields and entry history
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {ex_r, vc_r, ent_r, dbl_r} <= '0;
      end else begin
         ex_r  <= rd0 ? fld_rsp.rdata : ex_r;
         vc_r  <= rd2 ? fld_rsp.rdata : vc_r;
         ent_r <= (ent & ack) | (ent_r & !(res & ack));
         dbl_r <= (ent & ack) ? fld_req.wdata == 32'h8000_0B08 : dbl_r;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not OKAY");
   entry_rsv_a: assert property (ent |-> !(|fld_req.wdata[30:12]))
      else $error("entry reserved bits set");
   entry_copy_a: assert property (ent && !vc_r[31] |->
      fld_req.wdata == 0 || fld_req.wdata == {ex_r[31], 19'h0, ex_r[11:0]})
      else $error("bad exit copy");
   dbl_err_a: assert property (wr && fld_req.sel == 4'h6 && dbl_r
      |-> fld_req.wdata == 0) else $error("double fault code");
   req_hold_a: assert property (fld_req.req && !fld_rsp.ack
      |=> fld_req.req && $stable(fld_req)) else $error("request dropped");
   read_gap_a: assert property (ack && !fld_req.we &&
      fld_req.sel == 4'h8 |=> !fld_req.req [*2]) else $error("no gap");
   resume_order_a: assert property (res |-> ent_r)
      else $error("resume before entry");
   reset_idle_a: assert property (disable iff (1'b0)
      !hresetn |-> fld_req == '0) else $error("request in reset");
   dbl_c: cover property (ent && fld_req.wdata == 32'h8000_0B08);
   blk_c: cover property (wr && fld_req.sel == 4'h8);
   res_c: cover property (res && ack);
endmodule : gerr_top_props
bind gerr_top gerr_top_props u_props (.hclk, .hresetn, .hreadyout,
   .hresp, .fld_req, .fld_rsp);
`default_nettype wire

// file: tb/gerr_field_model.sv
// Purpose: Guest control structure field store with entry checks.
// Assumes: Fields preset by the bench.
// Notes:   Ack after at most lag idle cycles.
`timescale 1ns/1ns
`default_nettype none
module gerr_field_model (
   input  wire logic                    hclk,    // Clock
   input  wire logic                    hresetn, // Reset, low
   input  wire logic [3:0]              lag,     // Ack delay
   input  wire gerr_pkg::gerr_fld_req_t fld_req, // Request
   output var  gerr_pkg::gerr_fld_rsp_t fld_rsp  // Answer
);
   logic [31:0] fld [0:9];
   logic [3:0]  cnt_r;
   wire  logic  go  = fld_req.req && !fld_rsp.ack && cnt_r >= lag;
   wire  logic  nmi = fld[8][3] && fld[5][31] && fld[5][10:8] == 3'h2;
   wire  logic  bad = (|fld[5][30:12]) || nmi;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fld_rsp <= '0;
         cnt_r   <= '0;
      end else if (go) begin
         fld_rsp.ack   <= 1'b1;
         fld_rsp.rdata <= fld_req.sel == 4'h9 ? {31'h0, bad} : fld[fld_req.sel];
         if (fld_req.we && fld_req.sel != 4'h9) fld[fld_req.sel] <= fld_req.wdata;
         cnt_r <= '0;
      end else begin
         fld_rsp <= {1'b0, ~fld_rsp.rdata};
         cnt_r   <= fld_req.req ? cnt_r + 4'h1 : 4'h0;
      end
   end
endmodule : gerr_field_model
`default_nettype wire

// file: tb/gerr_top_tb.sv
// Purpose: Reflect and resume runs over AHB.
// Assumes: Zero wait slave.
// Notes:   Fields preset in the model.
`timescale 1ns/1ns
`default_nettype none
module gerr_top_tb;
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = '0;
   logic [1:0]  htrans  = '0;
   logic        hwrite  = 1'b0;
   logic [2:0]  hsize   = 3'h2;
   logic [31:0] hwdata  = '0;
   logic [3:0]  lag     = '0;
   logic [31:0] q;
   wire  logic  hready;
   wire  logic  hresp;
   wire  logic [31:0] hrdata;
   gerr_pkg::gerr_fld_req_t fld_req;
   gerr_pkg::gerr_fld_rsp_t fld_rsp;
   int err_total = 0;
   int tests_run = 0;
   int cyc       = 0;
   gerr_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .fld_req, .fld_rsp);
   gerr_field_model u_mdl (.hclk, .hresetn, .lag, .fld_req, .fld_rsp);
   always #5 hclk = ~hclk;
   task finish_test;
      $display("tests %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask : bus
   task run(input logic [3:0] c, input logic [15:0] ex, input logic [15:0] vc,
            input logic [15:0] en, input int e, input int i, input logic [2:0] s);
      logic [31:0] ent;
      ent = en != 0 ? {16'h8000, en} : 32'h0;
      u_mdl.fld[0] = {16'h8000, ex};
      u_mdl.fld[1] = 32'h1111;
      u_mdl.fld[2] = vc != 0 ? {16'h8000, vc} : 32'h0;
      u_mdl.fld[3] = 32'h3333;
      u_mdl.fld[4] = 32'h3;
      u_mdl.fld[5] = 32'h5555;
      u_mdl.fld[6] = 32'hFFFF;
      u_mdl.fld[7] = 32'h0;
      u_mdl.fld[8] = i == 2 ? 32'h8 : 32'h0;
      lag <= lag ^ 4'h3;
      bus(1'b1, 8'h00, {28'h0, c | 4'h1});
      q = 32'h0;
      while (q[1] !== 1'b1) bus(1'b0, 8'h04, 32'h0);
      chk(q, {26'h0, s[2], 1'b0, s[1], s[0], 2'b10});
      chk(u_mdl.fld[5], ent);
      chk(u_mdl.fld[6], e == 0 ? 32'hFFFF : e == 1 ? 32'h1111 :
         e == 2 ? 32'h3333 : 32'h0);
      chk(u_mdl.fld[7], c[1] && vc != 0 && vc[10:8] >= 3'h4 &&
         vc[10:8] <= 3'h6 ? 32'h3 : 32'h0);
      chk(u_mdl.fld[8], i == 1 ? 32'h8 : 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk(q, ent);
   endtask : run
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 8'h04, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'h00, 32'h8);
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h8);
      run(4'h4, 16'h1B0E, 16'h0, 16'h0B0E, 1, 0, 3'h0);
      run(4'h4, 16'h0B0E, 16'h0B0D, 16'h0B0E, 1, 0, 3'h4);
      run(4'h4, 16'h0B0D, 16'h0B0E, 16'h0B08, 3, 0, 3'h5);
      run(4'h4, 16'h0B0D, 16'h0B08, 16'h0, 0, 0, 3'h6);
      run(4'h4, 16'h0B0D, 16'h0301, 16'h0B0D, 1, 0, 3'h4);
      run(4'h2, 16'h130E, 16'h0, 16'h0, 0, 1, 3'h0);
      run(4'hE, 16'h130E, 16'h0, 16'h0, 0, 1, 3'h0);
      run(4'h2, 16'h1B08, 16'h0, 16'h0, 0, 0, 3'h0);
      run(4'h6, 16'h130E, 16'h0, 16'h0, 0, 0, 3'h0);
      run(4'hE, 16'h0B0E, 16'h1202, 16'h0202, 0, 2, 3'h4);
      run(4'h6, 16'h0B0D, 16'h0B0E, 16'h0B0E, 2, 0, 3'h4);
      run(4'h6, 16'h0B0D, 16'h0480, 16'h0480, 0, 0, 3'h4);
      finish_test();
   end
endmodule : gerr_top_tb
`default_nettype wire
